// File: hdl/adc_ctrl_pkg.sv
// Shared constants and types for the converter control block.
// Assumes a byte-wide register port and a separate analogue core.
package adc_ctrl_pkg;
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  OFS_RES_LO  = 4'h0;
    localparam logic [3:0]  OFS_RES_HI  = 4'h1;
    localparam logic [3:0]  OFS_CTRL0   = 4'h2;
    localparam logic [3:0]  OFS_CTRL1   = 4'h3;
    localparam logic [3:0]  OFS_CTRL2   = 4'h4;
    localparam logic [3:0]  OFS_DELAY   = 4'h5;
    localparam logic [3:0]  OFS_LOB_LO  = 4'h6;
    localparam logic [3:0]  OFS_LOB_HI  = 4'h7;
    localparam logic [3:0]  OFS_HIB_LO  = 4'h8;
    localparam logic [3:0]  OFS_HIB_HI  = 4'h9;
    localparam logic [3:0]  OFS_IRQ_ST  = 4'hA;
    localparam logic [3:0]  OFS_IRQ_MSK = 4'hB;
    // Control 0 fields
    localparam int          C0_START    = 7;
    localparam int          C0_BUSY     = 6;
    localparam int          C0_OFF      = 5;
    localparam int          C0_FMT      = 4;
    // Control 1 fields
    localparam int          C1_TRIG     = 7;
    localparam int          C1_DLY_EN   = 6;
    localparam int          C1_PWM_SRC  = 5;
    localparam int          C1_UPPER    = 4;
    localparam int          C1_LOWER    = 3;
    // Interrupt status bits
    localparam int          IRQ_EOC     = 0;
    localparam int          IRQ_BOUND   = 1;
    localparam int          IRQ_W       = 2;
    // Reset values
    localparam logic [7:0]  RST_CTRL0   = 8'h60;
    localparam logic [7:0]  RST_CTRL1   = 8'h00;
    localparam logic [1:0]  RST_CTRL2   = 2'h0;
    localparam logic [7:0]  RST_DELAY   = 8'h00;
    localparam logic [11:0] RST_BOUND   = 12'h000;
    // Boundary condition encodings
    localparam logic [1:0]  BND_INSIDE  = 2'h0;
    localparam logic [1:0]  BND_BELOW   = 2'h1;
    localparam logic [1:0]  BND_ABOVE   = 2'h2;
    localparam logic [1:0]  BND_OUTSIDE = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ARMED = 3'b001,
        ST_DELAY = 3'b010,
        ST_CONV  = 3'b011
    } conv_state_t;

    typedef struct packed {
        logic        start;
        logic [3:0]  channel;
        logic [2:0]  clk_div;
        logic        power_off;
    } core_cmd_t;

    typedef struct packed {
        logic        done;
        logic [11:0] data;
    } core_result_t;
endpackage : adc_ctrl_pkg

// File: hdl/adc_control_result_format.sv
// Control, result formatting and boundary compare for a 12-bit converter.
// Assumes core and PWM events are on clock; done is a one-cycle pulse.
//
// Contract
// RULE_01: Each 12-bit result is held split over a readable high and low byte.
// RULE_02: Format 0: high byte bits 11..4, low byte upper nibble bits 3..0.
// RULE_03: Format 1: low byte bits 7..0, high byte low nibble bits 11..8.
// RULE_04: Boundary pairs follow the same alignment as the result pair.
// RULE_05: Four-bit channel select routes one of nine inputs to the core.
// RULE_06: Compare each result with boundaries, interrupt on selected condition.
// RULE_07: PWM-triggered starts may insert a programmable delay.
// RULE_08: Control 0: start 7, busy 6, power off 5, format 4, channel 3..0.
// RULE_09: Control 1: trigger 7, delay 6, PWM source 5, bounds 4..3, clock 2..0.
// RULE_10: Control 2 holds only the PWM duty channel select in bits 1..0.
// RULE_11: An eight-bit writable delay register sets the PWM start delay.
// RULE_12: Result bytes are read only; writes leave them unchanged.
// RULE_13: Start bit rise resets core and sets busy; its fall starts conversion.
// RULE_14: Busy reads 1 during conversion; cleared at end with interrupt set.
// RULE_15: Delay equals register value times clock period; zero when disabled.
// RULE_16: Bounds select 00 inside, 01 at/below low, 10 at/above high, 11 either.
// RULE_17: Unused register bits read zero and ignore writes.
// RULE_18: The result path is twelve bits wide throughout.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
module adc_control_result_format (
    input  wire logic                        clock,
    input  wire logic                        reset_n,
    input  wire logic [3:0]                  address,
    input  wire logic [7:0]                  write_data,
    input  wire logic                        write_strobe,
    input  wire logic                        read_strobe,
    output logic      [7:0]                  read_data,
    input  wire logic                        pwm_period_irq,
    input  wire logic [2:0]                  pwm_duty_irq,
    output adc_ctrl_pkg::core_cmd_t          core_cmd,
    output logic                             core_reset,
    input  wire adc_ctrl_pkg::core_result_t  core_result,
    output logic                             irq
);
    logic [7:0]                  ctrl0;
    logic                        start_bit;
    logic                        busy;
    logic [5:0]                  control_low;
    logic [7:0]                  ctrl1;
    logic [1:0]                  ctrl2;
    logic [7:0]                  start_delay_count;
    logic [11:0]                 low_bound;
    logic [11:0]                 high_bound;
    logic [11:0]                 result;
    logic [adc_ctrl_pkg::IRQ_W-1:0] irq_status;
    logic [adc_ctrl_pkg::IRQ_W-1:0] irq_mask;
    adc_ctrl_pkg::conv_state_t   state;
    logic [7:0]                  delay_left;
    logic                        pwm_trig;
    logic                        start_rise;
    logic                        start_fall;
    logic                        bound_hit;
    logic                        wr;

    function automatic logic [15:0] pack12(input logic [11:0] v,
                                           input logic fmt);
        if (fmt)
            pack12 = {4'h0, v};
        else
            pack12 = {v, 4'h0};
    endfunction : pack12

    function automatic logic [11:0] merge12(input logic [11:0] old,
                                            input logic [7:0] b,
                                            input logic hi,
                                            input logic fmt);
        logic [15:0] p;
        p = pack12(old, fmt);
        if (hi)
            p[15:8] = b;
        else
            p[7:0] = b;
        merge12 = fmt ? p[11:0] : p[15:4];
    endfunction : merge12

    wire [15:0] res_pair = pack12(result, ctrl0[adc_ctrl_pkg::C0_FMT]);
    wire [15:0] lob_pair = pack12(low_bound, ctrl0[adc_ctrl_pkg::C0_FMT]);
    wire [15:0] hib_pair = pack12(high_bound, ctrl0[adc_ctrl_pkg::C0_FMT]);
    assign ctrl0 = {start_bit, busy, control_low};
    assign wr = write_strobe;
    // Level edges of software start bit
    assign start_rise = wr && address == adc_ctrl_pkg::OFS_CTRL0
        && write_data[adc_ctrl_pkg::C0_START]
        && !ctrl0[adc_ctrl_pkg::C0_START]; // RULE_13
    assign start_fall = wr && address == adc_ctrl_pkg::OFS_CTRL0
        && !write_data[adc_ctrl_pkg::C0_START]
        && ctrl0[adc_ctrl_pkg::C0_START]; // RULE_13
    // Code 11 of the duty select reuses the last channel
    assign pwm_trig = ctrl1[adc_ctrl_pkg::C1_PWM_SRC]
        ? pwm_duty_irq[(ctrl2 == 2'h3) ? 2'h2 : ctrl2]
        : pwm_period_irq; // RULE_10

    // Control registers; result bytes have no write path
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            start_bit <= adc_ctrl_pkg::RST_CTRL0[adc_ctrl_pkg::C0_START];
            control_low <= adc_ctrl_pkg::RST_CTRL0[5:0];
            ctrl1 <= adc_ctrl_pkg::RST_CTRL1;
            ctrl2 <= adc_ctrl_pkg::RST_CTRL2;
            start_delay_count <= adc_ctrl_pkg::RST_DELAY;
            irq_mask <= '0;
        end else if (wr) begin
            if (address == adc_ctrl_pkg::OFS_CTRL0) begin
                start_bit <= write_data[adc_ctrl_pkg::C0_START]; // RULE_08
                control_low <= write_data[5:0]; // RULE_08
            end else if (address == adc_ctrl_pkg::OFS_CTRL1) begin
                ctrl1 <= write_data; // RULE_09
            end else if (address == adc_ctrl_pkg::OFS_CTRL2) begin
                ctrl2 <= write_data[1:0]; // RULE_10 RULE_17
            end else if (address == adc_ctrl_pkg::OFS_DELAY) begin
                start_delay_count <= write_data; // RULE_11
            end else if (address == adc_ctrl_pkg::OFS_IRQ_MSK) begin
                irq_mask <= write_data[adc_ctrl_pkg::IRQ_W-1:0];
            end
        end
    end

    // Boundaries stored as 12-bit values, bytes mapped by format
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            low_bound <= adc_ctrl_pkg::RST_BOUND;
            high_bound <= adc_ctrl_pkg::RST_BOUND;
        end else if (wr) begin
            if (address == adc_ctrl_pkg::OFS_LOB_LO
                || address == adc_ctrl_pkg::OFS_LOB_HI) begin
                low_bound <= merge12(low_bound, write_data,
                    address == adc_ctrl_pkg::OFS_LOB_HI,
                    ctrl0[adc_ctrl_pkg::C0_FMT]); // RULE_04 RULE_17
            end else if (address == adc_ctrl_pkg::OFS_HIB_LO
                || address == adc_ctrl_pkg::OFS_HIB_HI) begin
                high_bound <= merge12(high_bound, write_data,
                    address == adc_ctrl_pkg::OFS_HIB_HI,
                    ctrl0[adc_ctrl_pkg::C0_FMT]); // RULE_04 RULE_17
            end
        end
    end

    // Conversion sequencing
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= adc_ctrl_pkg::ST_IDLE;
            delay_left <= 8'h00;
        end else begin
            case (state)
                adc_ctrl_pkg::ST_IDLE, adc_ctrl_pkg::ST_CONV: begin
                    if (ctrl0[adc_ctrl_pkg::C0_OFF]) begin
                        state <= adc_ctrl_pkg::ST_IDLE;
                    end else if (!ctrl1[adc_ctrl_pkg::C1_TRIG]) begin
                        if (start_rise)
                            state <= adc_ctrl_pkg::ST_ARMED; // RULE_13
                        else if (core_result.done)
                            state <= adc_ctrl_pkg::ST_IDLE; // RULE_14
                    end else if (pwm_trig
                        && state == adc_ctrl_pkg::ST_IDLE) begin
                        delay_left <= start_delay_count; // RULE_15
                        state <= (ctrl1[adc_ctrl_pkg::C1_DLY_EN]
                            && start_delay_count != 8'h00)
                            ? adc_ctrl_pkg::ST_DELAY
                            : adc_ctrl_pkg::ST_CONV; // RULE_07
                    end else if (core_result.done) begin
                        state <= adc_ctrl_pkg::ST_IDLE; // RULE_14
                    end
                end
                adc_ctrl_pkg::ST_ARMED: begin
                    if (start_fall)
                        state <= adc_ctrl_pkg::ST_CONV; // RULE_13
                end
                adc_ctrl_pkg::ST_DELAY: begin
                    // One clock period per count
                    if (delay_left == 8'h01)
                        state <= adc_ctrl_pkg::ST_CONV; // RULE_15
                    delay_left <= delay_left - 8'h01;
                end
                default: state <= adc_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    // Busy reads high out of reset, as the core is powered down
    always_ff @(posedge clock) begin
        if (!reset_n)
            busy <= adc_ctrl_pkg::RST_CTRL0[adc_ctrl_pkg::C0_BUSY];
        else if (start_rise && !ctrl1[adc_ctrl_pkg::C1_TRIG])
            busy <= 1'b1; // RULE_13
        else if (state == adc_ctrl_pkg::ST_CONV && core_result.done)
            busy <= 1'b0; // RULE_14
        else if (state == adc_ctrl_pkg::ST_DELAY
            || (pwm_trig && ctrl1[adc_ctrl_pkg::C1_TRIG]
                && state == adc_ctrl_pkg::ST_IDLE
                && !ctrl0[adc_ctrl_pkg::C0_OFF]))
            busy <= 1'b1;
    end

    // Full-width result capture
    always_ff @(posedge clock) begin
        if (!reset_n)
            result <= 12'h000;
        else if (state == adc_ctrl_pkg::ST_CONV && core_result.done)
            result <= core_result.data; // RULE_01 RULE_18
    end

    always_comb begin
        case (ctrl1[adc_ctrl_pkg::C1_UPPER:adc_ctrl_pkg::C1_LOWER]) // RULE_16
            adc_ctrl_pkg::BND_INSIDE:
                bound_hit = low_bound < core_result.data
                    && core_result.data < high_bound;
            adc_ctrl_pkg::BND_BELOW:
                bound_hit = core_result.data <= low_bound;
            adc_ctrl_pkg::BND_ABOVE:
                bound_hit = core_result.data >= high_bound;
            default:
                bound_hit = core_result.data <= low_bound
                    || core_result.data >= high_bound;
        endcase
    end

    // Sticky status; a new event wins over a write-one clear
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            irq_status <= '0;
        end else begin
            logic [adc_ctrl_pkg::IRQ_W-1:0] set;
            set = '0;
            set[adc_ctrl_pkg::IRQ_EOC] = state == adc_ctrl_pkg::ST_CONV
                && core_result.done; // RULE_14
            set[adc_ctrl_pkg::IRQ_BOUND] = state == adc_ctrl_pkg::ST_CONV
                && core_result.done && bound_hit; // RULE_06
            irq_status <= (irq_status
                & ~((wr && address == adc_ctrl_pkg::OFS_IRQ_ST)
                    ? write_data[adc_ctrl_pkg::IRQ_W-1:0] : '0)) | set;
        end
    end

    assign irq = |(irq_status & irq_mask);

    assign core_cmd.start = state == adc_ctrl_pkg::ST_ARMED && start_fall
        || state == adc_ctrl_pkg::ST_DELAY && delay_left == 8'h01
        || state == adc_ctrl_pkg::ST_IDLE && pwm_trig
           && ctrl1[adc_ctrl_pkg::C1_TRIG] && !ctrl0[adc_ctrl_pkg::C0_OFF]
           && !(ctrl1[adc_ctrl_pkg::C1_DLY_EN]
                && start_delay_count != 8'h00); // RULE_07
    assign core_cmd.channel = ctrl0[3:0]; // RULE_05
    assign core_cmd.clk_div = ctrl1[2:0];
    assign core_cmd.power_off = ctrl0[adc_ctrl_pkg::C0_OFF];
    assign core_reset = state == adc_ctrl_pkg::ST_ARMED; // RULE_13

    // Read port, one cycle latency, unmapped reads zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            read_data <= 8'h00;
        end else if (read_strobe) begin
            if (address == adc_ctrl_pkg::OFS_RES_LO)
                read_data <= res_pair[7:0]; // RULE_02 RULE_03
            else if (address == adc_ctrl_pkg::OFS_RES_HI)
                read_data <= res_pair[15:8]; // RULE_02 RULE_03
            else if (address == adc_ctrl_pkg::OFS_CTRL0)
                read_data <= ctrl0;
            else if (address == adc_ctrl_pkg::OFS_CTRL1)
                read_data <= ctrl1;
            else if (address == adc_ctrl_pkg::OFS_CTRL2)
                read_data <= {6'h00, ctrl2}; // RULE_17
            else if (address == adc_ctrl_pkg::OFS_DELAY)
                read_data <= start_delay_count;
            else if (address == adc_ctrl_pkg::OFS_LOB_LO)
                read_data <= lob_pair[7:0]; // RULE_04
            else if (address == adc_ctrl_pkg::OFS_LOB_HI)
                read_data <= lob_pair[15:8]; // RULE_04
            else if (address == adc_ctrl_pkg::OFS_HIB_LO)
                read_data <= hib_pair[7:0]; // RULE_04
            else if (address == adc_ctrl_pkg::OFS_HIB_HI)
                read_data <= hib_pair[15:8]; // RULE_04
            else if (address == adc_ctrl_pkg::OFS_IRQ_ST)
                read_data <= {6'h00, irq_status};
            else if (address == adc_ctrl_pkg::OFS_IRQ_MSK)
                read_data <= {6'h00, irq_mask};
            else
                read_data <= 8'h00;
        end else begin
            read_data <= 8'h00;
        end
    end

    property p_busy_clear_on_done;
        @(posedge clock) disable iff (!reset_n)
        state == adc_ctrl_pkg::ST_CONV && core_result.done
            |=> !ctrl0[adc_ctrl_pkg::C0_BUSY]
                && irq_status[adc_ctrl_pkg::IRQ_EOC];
    endproperty
    a_busy_clear_on_done: assert property (p_busy_clear_on_done) // RULE_14
        else $error("busy not cleared at conversion end");

    property p_rise_sets_busy;
        @(posedge clock) disable iff (!reset_n)
        start_rise && !ctrl1[adc_ctrl_pkg::C1_TRIG]
            |=> ctrl0[adc_ctrl_pkg::C0_BUSY] && core_reset;
    endproperty
    a_rise_sets_busy: assert property (p_rise_sets_busy) // RULE_13
        else $error("start rise did not reset core");

    property p_result_kept;
        @(posedge clock) disable iff (!reset_n)
        !(state == adc_ctrl_pkg::ST_CONV && core_result.done)
            |=> result == $past(result);
    endproperty
    a_result_kept: assert property (p_result_kept) // RULE_12
        else $error("result changed without conversion");

    property p_ctrl2_read;
        @(posedge clock) disable iff (!reset_n)
        read_strobe && address == adc_ctrl_pkg::OFS_CTRL2
            |=> read_data[7:2] == 6'h00;
    endproperty
    a_ctrl2_read: assert property (p_ctrl2_read) // RULE_17
        else $error("unused control bits read nonzero");

    property p_delay_length;
        @(posedge clock) disable iff (!reset_n)
        state == adc_ctrl_pkg::ST_DELAY && delay_left != 8'h01
            |=> state == adc_ctrl_pkg::ST_DELAY
                && delay_left == $past(delay_left) - 8'h01;
    endproperty
    a_delay_length: assert property (p_delay_length) // RULE_15
        else $error("start delay length wrong");

    property p_format_hi;
        @(posedge clock) disable iff (!reset_n)
        read_strobe && address == adc_ctrl_pkg::OFS_RES_HI && ctrl0[4]
            |=> read_data[7:4] == 4'h0;
    endproperty
    a_format_hi: assert property (p_format_hi) // RULE_03
        else $error("high nibble not zero in right format");

    property p_format_lo;
        @(posedge clock) disable iff (!reset_n)
        read_strobe && address == adc_ctrl_pkg::OFS_RES_LO && !ctrl0[4]
            |=> read_data == {$past(result[3:0]), 4'h0};
    endproperty
    a_format_lo: assert property (p_format_lo) // RULE_02
        else $error("left format low byte wrong");

    property p_bound_irq;
        @(posedge clock) disable iff (!reset_n)
        state == adc_ctrl_pkg::ST_CONV && core_result.done
            && core_result.data <= low_bound && ctrl1[4:3] == 2'h1
            |=> irq_status[adc_ctrl_pkg::IRQ_BOUND];
    endproperty
    a_bound_irq: assert property (p_bound_irq) // RULE_06
        else $error("boundary interrupt missed");
endmodule : adc_control_result_format

// File: test/test_adc_control_result_format.sv
// Self-checking bench for the converter control and result format block.
// Assumes the package offsets and a register read answered one cycle late.
`timescale 1ns/100ps
module test_adc_control_result_format;
    logic                       clock = 1'b0;
    logic                       reset_n;
    logic [3:0]                 address;
    logic [7:0]                 write_data;
    logic                       write_strobe;
    logic                       read_strobe;
    logic [7:0]                 read_data;
    logic                       pwm_period_irq;
    logic [2:0]                 pwm_duty_irq;
    adc_ctrl_pkg::core_cmd_t    core_cmd;
    logic                       core_reset;
    adc_ctrl_pkg::core_result_t core_result;
    logic                       irq;
    int                         errors;
    int                         samples_checked;
    int                         cycles;
    int                         lo_b = 12'h35A;
    int                         hi_b = 12'hC96;
    int                         st;
    logic [31:0]                seed = 32'h0FDA4B8D;
    logic [11:0]                d;
    logic [3:0]                 ch;
    logic [1:0]                 sel;

    adc_control_result_format uut (
        .clock          (clock),
        .reset_n        (reset_n),
        .address        (address),
        .write_data     (write_data),
        .write_strobe   (write_strobe),
        .read_strobe    (read_strobe),
        .read_data      (read_data),
        .pwm_period_irq (pwm_period_irq),
        .pwm_duty_irq   (pwm_duty_irq),
        .core_cmd       (core_cmd),
        .core_reset     (core_reset),
        .core_result    (core_result),
        .irq            (irq)
    );

    initial forever #4 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] hi_byte(input int v, input logic f);
        hi_byte = f ? 8'((v >> 8) & 15) : 8'((v >> 4) & 255);
    endfunction : hi_byte
    function automatic logic [7:0] lo_byte(input int v, input logic f);
        lo_byte = f ? 8'(v & 255) : 8'((v & 15) << 4);
    endfunction : lo_byte
    function automatic int hit(input int v, input int m);
        case (m)
            0:       hit = int'(lo_b < v && v < hi_b);
            1:       hit = int'(v <= lo_b);
            2:       hit = int'(v >= hi_b);
            default: hit = int'(v <= lo_b || v >= hi_b);
        endcase
    endfunction : hit

    task automatic test_done();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic check_byte(input logic [7:0] g, input logic [7:0] e,
                              input string msg);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %h not %h", $time, msg, g, e);
        end
    endtask : check_byte
    task automatic check_count(input int g, input int e, input string msg);
        samples_checked++;
        if (g != e) begin
            errors++;
            $display("wrong value at %0t: %s got %0d not %0d", $time, msg, g, e);
        end
    endtask : check_count
    // Strobe drops one edge before the next request may raise it
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        address      <= a;
        write_data   <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(negedge clock);
    endtask : wr
    task automatic rd_check(input logic [3:0] a, input logic [7:0] e,
                            input string msg);
        @(posedge clock);
        address     <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(negedge clock);
        check_byte(read_data, e, msg);
    endtask : rd_check
    task automatic wait_start(input int limit, output int k);
        for (k = 0; k <= limit; k++) begin
            @(negedge clock);
            if (core_cmd.start === 1'b1) break;
            @(posedge clock);
            pwm_period_irq <= 1'b0;
            pwm_duty_irq   <= 3'b000;
        end
    endtask : wait_start
    // Data lines turn over after done so a stale value cannot pass
    task automatic finish_conv(input logic [11:0] v);
        @(posedge clock);
        pwm_period_irq <= 1'b0;
        pwm_duty_irq   <= 3'b000;
        write_strobe   <= 1'b0;
        core_result    <= {1'b1, v};
        @(posedge clock);
        core_result    <= {1'b0, ~v};
    endtask : finish_conv
    task automatic convert(input logic [3:0] c, input logic f,
                           input logic [11:0] v);
        logic [7:0] c0;
        int         k;
        c0 = {3'b000, f, c};
        wr(adc_ctrl_pkg::OFS_CTRL0, c0 | 8'h80);
        rd_check(adc_ctrl_pkg::OFS_CTRL0, c0 | 8'hC0, "armed");
        check_byte({7'h00, core_reset}, 8'h01, "core reset");
        @(posedge clock);
        write_data   <= c0;
        write_strobe <= 1'b1;
        wait_start(8, k);
        check_count(k, 0, "software start");
        check_byte({4'h0, core_cmd.channel}, {4'h0, c}, "channel");
        finish_conv(v);
    endtask : convert
    task automatic pwm_try(input logic per, input logic [2:0] duty,
                           input int limit, input int e);
        int k;
        @(posedge clock);
        pwm_period_irq <= per;
        pwm_duty_irq   <= duty;
        wait_start(limit, k);
        check_count(k, e, "pwm start");
        finish_conv(seed[11:0]);
        wr(adc_ctrl_pkg::OFS_IRQ_ST, 8'h03);
    endtask : pwm_try

    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            errors++;
            $display("wrong value at %0t: run timed out", $time);
            test_done();
        end
    end

    initial begin
        {reset_n, address, write_data, write_strobe, read_strobe} = '0;
        {pwm_period_irq, pwm_duty_irq, core_result} = '0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        rd_check(adc_ctrl_pkg::OFS_CTRL0, 8'h60, "ctrl0 reset");
        rd_check(adc_ctrl_pkg::OFS_CTRL1, 8'h00, "ctrl1 reset");
        rd_check(adc_ctrl_pkg::OFS_CTRL2, 8'h00, "ctrl2 reset");
        rd_check(adc_ctrl_pkg::OFS_DELAY, 8'h00, "delay reset");
        rd_check(4'hC, 8'h00, "unmapped");
        check_byte({7'h00, irq}, 8'h00, "irq reset");
        $display("test reset values done");
        seed = lfsr(seed);
        wr(adc_ctrl_pkg::OFS_CTRL1, seed[7:0]);
        rd_check(adc_ctrl_pkg::OFS_CTRL1, seed[7:0], "ctrl1");
        check_byte({5'h00, core_cmd.clk_div}, {5'h00, seed[2:0]}, "div");
        wr(adc_ctrl_pkg::OFS_CTRL2, 8'hFF);
        rd_check(adc_ctrl_pkg::OFS_CTRL2, 8'h03, "ctrl2");
        wr(adc_ctrl_pkg::OFS_DELAY, seed[15:8]);
        rd_check(adc_ctrl_pkg::OFS_DELAY, seed[15:8], "delay");
        wr(adc_ctrl_pkg::OFS_DELAY, 8'h00);
        wr(adc_ctrl_pkg::OFS_CTRL1, 8'h00);
        for (int c = 0; c < 9; c++) begin
            wr(adc_ctrl_pkg::OFS_CTRL0, 8'(c));
            check_byte({4'h0, core_cmd.channel}, 8'(c), "route");
            check_byte({7'h00, core_cmd.power_off}, 8'h00, "power");
        end
        wr(adc_ctrl_pkg::OFS_LOB_HI, hi_byte(lo_b, 1'b0));
        wr(adc_ctrl_pkg::OFS_LOB_LO, lo_byte(lo_b, 1'b0) | 8'h0F);
        wr(adc_ctrl_pkg::OFS_HIB_HI, hi_byte(hi_b, 1'b0));
        wr(adc_ctrl_pkg::OFS_HIB_LO, lo_byte(hi_b, 1'b0) | 8'h0F);
        wr(adc_ctrl_pkg::OFS_CTRL0, 8'h10);
        rd_check(adc_ctrl_pkg::OFS_LOB_HI, hi_byte(lo_b, 1'b1), "lb hi");
        rd_check(adc_ctrl_pkg::OFS_LOB_LO, lo_byte(lo_b, 1'b1), "lb lo");
        rd_check(adc_ctrl_pkg::OFS_HIB_HI, hi_byte(hi_b, 1'b1), "hb hi");
        rd_check(adc_ctrl_pkg::OFS_HIB_LO, lo_byte(hi_b, 1'b1), "hb lo");
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            wr(adc_ctrl_pkg::OFS_CTRL1, 8'(m << 3));
            wr(adc_ctrl_pkg::OFS_IRQ_MSK, 8'(m));
            for (int j = 0; j < 4; j++) begin
                seed = lfsr(seed);
                d = (j == 0) ? 12'(lo_b) : (j == 1) ? 12'(hi_b) :
                    (j == 2) ? 12'h800 : seed[11:0];
                ch = 4'((m * 4 + j) % 9);
                convert(ch, j[0], d);
                st = 1 | (hit(int'(d), m) << 1);
                rd_check(adc_ctrl_pkg::OFS_IRQ_ST, 8'(st), "status");
                check_byte({7'h00, irq}, 8'((st & m) != 0), "irq");
                rd_check(adc_ctrl_pkg::OFS_CTRL0, {3'b000, j[0], ch}, "eoc");
                if (m == 0 && j == 0) begin
                    wr(adc_ctrl_pkg::OFS_RES_HI, ~hi_byte(d, j[0]));
                    wr(adc_ctrl_pkg::OFS_RES_LO, ~lo_byte(d, j[0]));
                end
                rd_check(adc_ctrl_pkg::OFS_RES_HI, hi_byte(d, j[0]), "rhi");
                rd_check(adc_ctrl_pkg::OFS_RES_LO, lo_byte(d, j[0]), "rlo");
                wr(adc_ctrl_pkg::OFS_IRQ_ST, 8'h03);
                rd_check(adc_ctrl_pkg::OFS_IRQ_ST, 8'h00, "cleared");
                check_byte({7'h00, irq}, 8'h00, "irq clear");
            end
        end
        $display("test conversions and boundaries done");
        wr(adc_ctrl_pkg::OFS_CTRL1, 8'h80);
        pwm_try(1'b1, 3'b000, 20, 0);
        seed = lfsr(seed);
        wr(adc_ctrl_pkg::OFS_DELAY, seed[7:0] | 8'h02);
        wr(adc_ctrl_pkg::OFS_CTRL1, 8'hC0);
        pwm_try(1'b1, 3'b000, 300, int'(seed[7:0] | 8'h02));
        wr(adc_ctrl_pkg::OFS_DELAY, 8'h00);
        wr(adc_ctrl_pkg::OFS_CTRL1, 8'hA0);
        for (int k = 0; k < 4; k++) begin
            sel = (k == 3) ? 2'd2 : 2'(k);
            wr(adc_ctrl_pkg::OFS_CTRL2, 8'(k));
            pwm_try(1'b0, 3'(1 << sel), 20, 0);
            pwm_try(1'b0, 3'(1 << ((sel + 1) % 3)), 20, 21);
        end
        // Powered-down converter must ignore triggers
        wr(adc_ctrl_pkg::OFS_CTRL0, 8'h20);
        wr(adc_ctrl_pkg::OFS_CTRL1, 8'h80);
        check_byte({7'h00, core_cmd.power_off}, 8'h01, "off");
        pwm_try(1'b1, 3'b000, 20, 21);
        $display("test pwm triggers done");
        test_done();
    end
endmodule : test_adc_control_result_format
